// ===== rtl/idw_consts.vh
// constants for the inter-domain window check: register map, field positions, codes
// assumes a 32-bit AXI4-Lite slave port and a 12-bit byte address space
`ifndef IDW_CONSTS_VH
`define IDW_CONSTS_VH

// global registers
`define IDW_OFS_STAT     12'h000
`define IDW_OFS_MASK     12'h004
// entry i sits at ENT_BASE + i * 32
`define IDW_ENT_PAGE     4'h1
`define IDW_W_CTRL       3'h0
`define IDW_W_SUBM       3'h1
`define IDW_W_ACC        3'h2
`define IDW_W_BASE_LO    3'h3
`define IDW_W_BASE_HI    3'h4
`define IDW_W_SIZE_LO    3'h5
`define IDW_W_SIZE_HI    3'h6
// control word fields
`define IDW_B_USABLE     0
`define IDW_B_ALLOW_UPD  1
`define IDW_B_TYPE_LO    2
`define IDW_B_TYPE_HI    3
`define IDW_B_WEN        4
`define IDW_B_MODE       5
`define IDW_B_RD         6
`define IDW_B_WR         7
// entry types and window modes
`define IDW_TYPE_SINGLE  2'h0
`define IDW_TYPE_MULTI   2'h1
`define IDW_MODE_ADDR    1'h0
`define IDW_MODE_OFS     1'h1
// check result codes
`define IDW_RC_OK        3'h0
`define IDW_RC_HANDLE    3'h1
`define IDW_RC_SUBM      3'h2
`define IDW_RC_MISCFG    3'h3
`define IDW_RC_PERM      3'h4
`define IDW_RC_WINDOW    3'h5
// interrupt status bits
`define IDW_IRQ_DENY     0
`define IDW_IRQ_UPD      1
`define IDW_IRQ_FAULT    2
`define IDW_IRQ_W        3
// bus answers
`define IDW_RESP_OKAY    2'h0
`define IDW_RESP_SLVERR  2'h2
// top of the 64-bit space, one past the last address
`define IDW_ADDR_TOP     66'h1_0000_0000_0000_0000

`endif

// ===== rtl/idw_check.v
// inter-domain window check: permission table, window and permission check,
// update-window with drain, fault completion record, AXI4-Lite registers
// assumes the memory path returns bitmap results and reports faults and completions
`include "idw_consts.vh"
`default_nettype none

module idw_check #(
   parameter N   = 4,
   parameter HW  = 2,
   parameter CW  = 8
) (
   // clock and reset
   input  wire         mclk,
   input  wire         rst_b,
   // axi4-lite slave
   input  wire         s_axi_awvalid,
   output wire         s_axi_awready,
   input  wire [11:0]  s_axi_awaddr,
   input  wire         s_axi_wvalid,
   output wire         s_axi_wready,
   input  wire [31:0]  s_axi_wdata,
   input  wire [3:0]   s_axi_wstrb,
   output wire         s_axi_bvalid,
   input  wire         s_axi_bready,
   output wire [1:0]   s_axi_bresp,
   input  wire         s_axi_arvalid,
   output wire         s_axi_arready,
   input  wire [11:0]  s_axi_araddr,
   output wire         s_axi_rvalid,
   input  wire         s_axi_rready,
   output wire [31:0]  s_axi_rdata,
   output wire [1:0]   s_axi_rresp,
   // descriptor access check
   input  wire         chk_valid,
   input  wire [HW-1:0] chk_handle,
   input  wire [19:0]  chk_pasid,
   input  wire         chk_bm_ok,
   input  wire         chk_rd,
   input  wire         chk_wr,
   input  wire [63:0]  chk_addr,
   input  wire [63:0]  chk_size,
   output wire         chk_done,
   output wire [2:0]   chk_code,
   output wire [HW-1:0] chk_res_handle,
   output wire [19:0]  chk_acc_pasid,
   output wire [63:0]  chk_eff_addr,
   // descriptor retirement
   input  wire         desc_done,
   input  wire [HW-1:0] desc_done_handle,
   // update window
   input  wire         upd_valid,
   output wire         upd_ready,
   input  wire [HW-1:0] upd_handle,
   input  wire [19:0]  upd_pasid,
   input  wire         upd_no_drain,
   input  wire [63:0]  upd_base,
   input  wire [63:0]  upd_size,
   input  wire         upd_mode,
   input  wire         upd_rd,
   input  wire         upd_wr,
   input  wire         upd_wen,
   output wire         upd_done,
   output wire         upd_err,
   // alternate address space fault
   input  wire         flt_valid,
   input  wire [HW-1:0] flt_handle,
   input  wire         flt_block,
   input  wire [1:0]   flt_operand,
   input  wire [31:0]  flt_bytes,
   input  wire [63:0]  flt_addr,
   input  wire         flt_resolved,
   output wire         flt_wait,
   output wire         flt_resume,
   output wire         cmp_valid,
   output wire [HW-1:0] cmp_handle,
   output wire [63:0]  cmp_fault_addr,
   output wire         cmp_addr_masked,
   output wire [1:0]   cmp_operand,
   output wire [31:0]  cmp_bytes,
   // interrupt
   output wire         irq
);

   localparam ST_IDLE  = 2'b01;
   localparam ST_DRAIN = 2'b10;

   // ------------------------------------------------------------
   // permission table storage
   // ------------------------------------------------------------
   reg [7:0]  ctrl_q [0:N-1];
   reg [19:0] subm_q [0:N-1];
   reg [19:0] acc_q  [0:N-1];
   reg [63:0] base_q [0:N-1];
   reg [63:0] size_q [0:N-1];
   reg [CW-1:0] infl_q [0:N-1];
   reg [`IDW_IRQ_W-1:0] stat_q, mask_q;

   // bus state
   reg         aw_q, w_q, bv_q, rv_q;
   reg [11:0]  awa_q;
   reg [31:0]  wd_q, rd_q;
   reg [3:0]   ws_q;
   reg [1:0]   br_q, rr_q;

   // check, update and fault state
   reg          cd_q;
   reg [2:0]    cc_q;
   reg [HW-1:0] ch_q, uh_q, fh_q;
   reg [19:0]   cp_q;
   reg [63:0]   ce_q;
   reg [1:0]    st_q;
   reg          ud_q, ue_q, fw_q, fr_q, cv_q, cm_q;
   reg [63:0]   fa_q;
   reg [1:0]    fo_q;
   reg [31:0]   fb_q;
   integer      i;

   function is_ent;
      input [11:0] a;
      is_ent = (a[11:8] == `IDW_ENT_PAGE) && (a[7:5] < N) && (a[4:2] <= `IDW_W_SIZE_HI);
   endfunction

   // register view shared by reads and write merging
   function [31:0] reg_view;
      input [11:0] a;
      reg [HW-1:0] x;
      begin
         x = a[5+HW-1:5];
         reg_view = 32'h0000_0000;
         if (a == `IDW_OFS_STAT)
            reg_view = {29'h0, stat_q};
         else if (a == `IDW_OFS_MASK)
            reg_view = {29'h0, mask_q};
         else if (is_ent(a)) begin
            case (a[4:2])
               `IDW_W_CTRL:    reg_view = {24'h0, ctrl_q[x]};
               `IDW_W_SUBM:    reg_view = {12'h0, subm_q[x]};
               `IDW_W_ACC:     reg_view = {12'h0, acc_q[x]};
               `IDW_W_BASE_LO: reg_view = base_q[x][31:0];
               `IDW_W_BASE_HI: reg_view = base_q[x][63:32];
               `IDW_W_SIZE_LO: reg_view = size_q[x][31:0];
               `IDW_W_SIZE_HI: reg_view = size_q[x][63:32];
               default:        reg_view = 32'h0000_0000;
            endcase
         end
      end
   endfunction

   function [31:0] bmerge;
      input [31:0] o, n;
      input [3:0]  s;
      integer k;
      begin
         bmerge = o;
         for (k = 0; k < 4; k = k + 1)
            if (s[k])
               bmerge[k*8 +: 8] = n[k*8 +: 8];
      end
   endfunction

   // carry-wide bounds
   // 66-bit sums so a region end or window end past the top never wraps back inside
   function win_ok;
      input [63:0] b, w, a, s;
      input        m;
      reg [65:0] lim, st, en;
      begin
         lim = {2'b00, b} + {2'b00, w};
         st  = (m == `IDW_MODE_OFS) ? ({2'b00, b} + {2'b00, a}) : {2'b00, a};
         en  = st + {2'b00, s};
         win_ok = (st >= {2'b00, b}) && (en <= lim) && (lim <= `IDW_ADDR_TOP);
      end
   endfunction

   // ------------------------------------------------------------
   // axi4-lite handshake
   // ------------------------------------------------------------
   wire        wr_go  = aw_q && w_q && !bv_q;
   wire [31:0] wr_val = bmerge(reg_view(awa_q), wd_q, ws_q);
   wire        wr_ent = wr_go && is_ent(awa_q);
   wire [HW-1:0] wr_x = awa_q[5+HW-1:5];
   wire        wr_ok  = (awa_q == `IDW_OFS_STAT) || (awa_q == `IDW_OFS_MASK) || is_ent(awa_q);

   assign s_axi_awready = !aw_q && !bv_q;
   assign s_axi_wready  = !w_q && !bv_q;
   assign s_axi_bvalid  = bv_q;
   assign s_axi_bresp   = br_q;
   assign s_axi_arready = !rv_q;
   assign s_axi_rvalid  = rv_q;
   assign s_axi_rdata   = rd_q;
   assign s_axi_rresp   = rr_q;

   always @(posedge mclk) begin
      if (!rst_b) begin
         aw_q  <= 1'b0;
         w_q   <= 1'b0;
         bv_q  <= 1'b0;
         rv_q  <= 1'b0;
         awa_q <= 12'h000;
         wd_q  <= 32'h0000_0000;
         ws_q  <= 4'h0;
         br_q  <= `IDW_RESP_OKAY;
         rd_q  <= 32'h0000_0000;
         rr_q  <= `IDW_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q  <= 1'b1;
            awa_q <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q  <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_q <= 1'b0;
            w_q  <= 1'b0;
            bv_q <= 1'b1;
            br_q <= wr_ok ? `IDW_RESP_OKAY : `IDW_RESP_SLVERR;
         end else if (bv_q && s_axi_bready)
            bv_q <= 1'b0;
         if (s_axi_arvalid && s_axi_arready) begin
            rv_q <= 1'b1;
            rd_q <= reg_view({s_axi_araddr[11:2], 2'b00});
            rr_q <= (s_axi_araddr[11:2] == 10'h000 || s_axi_araddr[11:2] == 10'h001 ||
                     is_ent({s_axi_araddr[11:2], 2'b00})) ? `IDW_RESP_OKAY : `IDW_RESP_SLVERR;
         end else if (rv_q && s_axi_rready)
            rv_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // access check
   // ------------------------------------------------------------
   wire          c_hv = (chk_handle < N);
   wire [HW-1:0] c_x  = c_hv ? chk_handle : {HW{1'b0}};
   wire [7:0]    c_ct = ctrl_q[c_x];
   wire [1:0]    c_ty = c_ct[`IDW_B_TYPE_HI:`IDW_B_TYPE_LO];
   wire          c_wok = win_ok(base_q[c_x], size_q[c_x], chk_addr, chk_size, c_ct[`IDW_B_MODE]);
   reg  [2:0]    c_rc;

   always @* begin
      if (!c_hv || !c_ct[`IDW_B_USABLE])
         c_rc = `IDW_RC_HANDLE;
      else if (c_ty != `IDW_TYPE_SINGLE && c_ty != `IDW_TYPE_MULTI)
         c_rc = `IDW_RC_MISCFG;
      // entry id or bitmap by type
      else if ((c_ty == `IDW_TYPE_SINGLE && chk_pasid != subm_q[c_x]) ||
               (c_ty == `IDW_TYPE_MULTI && !chk_bm_ok))
         c_rc = `IDW_RC_SUBM;
      else if ((chk_rd && !c_ct[`IDW_B_RD]) || (chk_wr && !c_ct[`IDW_B_WR]))
         c_rc = `IDW_RC_PERM;
      else if (c_ct[`IDW_B_WEN] && !c_wok)
         c_rc = `IDW_RC_WINDOW;
      else
         c_rc = `IDW_RC_OK;
   end

   wire c_grant = chk_valid && (c_rc == `IDW_RC_OK);

   always @(posedge mclk) begin
      if (!rst_b) begin
         cd_q <= 1'b0;
         cc_q <= `IDW_RC_OK;
         ch_q <= {HW{1'b0}};
         cp_q <= 20'h00000;
         ce_q <= 64'h0;
      end else begin
         cd_q <= chk_valid;
         if (chk_valid) begin
            cc_q <= c_rc;
            ch_q <= chk_handle;
            cp_q <= acc_q[c_x];
            ce_q <= (c_ct[`IDW_B_WEN] && c_ct[`IDW_B_MODE] == `IDW_MODE_OFS) ?
                    base_q[c_x] + chk_addr : chk_addr;
         end
      end
   end

   assign chk_done       = cd_q;
   assign chk_code       = cc_q;
   assign chk_res_handle = ch_q;
   assign chk_acc_pasid  = cp_q;
   assign chk_eff_addr   = ce_q;

   // ------------------------------------------------------------
   // in-flight counters, one per entry
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_infl
         wire inc = c_grant && (c_x == g);
         wire dec = desc_done && (desc_done_handle == g) && (infl_q[g] != {CW{1'b0}});
         always @(posedge mclk) begin
            if (!rst_b)
               infl_q[g] <= {CW{1'b0}};
            else if (inc && !dec)
               infl_q[g] <= infl_q[g] + {{(CW-1){1'b0}}, 1'b1};
            else if (dec && !inc)
               infl_q[g] <= infl_q[g] - {{(CW-1){1'b0}}, 1'b1};
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // update window
   // ------------------------------------------------------------
   wire          u_go = upd_valid && upd_ready;
   wire          u_hv = (upd_handle < N);
   wire [HW-1:0] u_x  = u_hv ? upd_handle : {HW{1'b0}};
   wire [1:0]    u_ty = ctrl_q[u_x][`IDW_B_TYPE_HI:`IDW_B_TYPE_LO];
   wire          u_bad = !u_hv || !ctrl_q[u_x][`IDW_B_ALLOW_UPD] ||
                         (u_ty != `IDW_TYPE_SINGLE && u_ty != `IDW_TYPE_MULTI) ||
                         (upd_pasid != acc_q[u_x]);
   wire          u_wr = u_go && !u_bad;

   assign upd_ready = (st_q == ST_IDLE);

   always @(posedge mclk) begin
      if (!rst_b) begin
         st_q <= ST_IDLE;
         uh_q <= {HW{1'b0}};
         ud_q <= 1'b0;
         ue_q <= 1'b0;
      end else begin
         ud_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (u_go) begin
                  uh_q <= u_x;
                  if (u_bad || upd_no_drain) begin
                     ud_q <= 1'b1;
                     ue_q <= u_bad;
                  end else
                     st_q <= ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               // wait for old users
               // counts every holder of the entry, so late arrivals also delay completion
               if (infl_q[uh_q] == {CW{1'b0}}) begin
                  ud_q <= 1'b1;
                  ue_q <= 1'b0;
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   assign upd_done = ud_q;
   assign upd_err  = ue_q;

   // ------------------------------------------------------------
   // table writes: bus and update window
   // ------------------------------------------------------------
   always @(posedge mclk) begin
      if (!rst_b) begin
         for (i = 0; i < N; i = i + 1) begin
            ctrl_q[i] <= 8'h00;
            subm_q[i] <= 20'h00000;
            acc_q[i]  <= 20'h00000;
            base_q[i] <= 64'h0;
            size_q[i] <= 64'h0;
         end
      end else if (u_wr) begin
         ctrl_q[u_x][`IDW_B_WEN]  <= upd_wen;
         ctrl_q[u_x][`IDW_B_MODE] <= upd_mode;
         ctrl_q[u_x][`IDW_B_RD]   <= upd_rd;
         ctrl_q[u_x][`IDW_B_WR]   <= upd_wr;
         base_q[u_x] <= upd_base;
         size_q[u_x] <= upd_size;
      end else if (wr_ent) begin
         if (awa_q[4:2] == `IDW_W_CTRL && ctrl_q[wr_x][`IDW_B_USABLE])
            ctrl_q[wr_x][`IDW_B_USABLE] <= wr_val[`IDW_B_USABLE];
         else if (!ctrl_q[wr_x][`IDW_B_USABLE]) begin
            case (awa_q[4:2])
               `IDW_W_CTRL:    ctrl_q[wr_x] <= wr_val[7:0];
               `IDW_W_SUBM:    subm_q[wr_x] <= wr_val[19:0];
               `IDW_W_ACC:     acc_q[wr_x]  <= wr_val[19:0];
               `IDW_W_BASE_LO: base_q[wr_x][31:0]  <= wr_val;
               `IDW_W_BASE_HI: base_q[wr_x][63:32] <= wr_val;
               `IDW_W_SIZE_LO: size_q[wr_x][31:0]  <= wr_val;
               `IDW_W_SIZE_HI: size_q[wr_x][63:32] <= wr_val;
               default:        ctrl_q[wr_x] <= ctrl_q[wr_x];
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // fault completion record
   // ------------------------------------------------------------
   wire          f_hv = (flt_handle < N);
   wire [HW-1:0] f_x  = f_hv ? flt_handle : {HW{1'b0}};
   wire          f_ofs = ctrl_q[f_x][`IDW_B_MODE] == `IDW_MODE_OFS;

   always @(posedge mclk) begin
      if (!rst_b) begin
         fw_q <= 1'b0;
         fr_q <= 1'b0;
         cv_q <= 1'b0;
         fh_q <= {HW{1'b0}};
         fa_q <= 64'h0;
         cm_q <= 1'b0;
         fo_q <= 2'h0;
         fb_q <= 32'h0000_0000;
      end else begin
         cv_q <= 1'b0;
         fr_q <= 1'b0;
         if (fw_q) begin
            if (flt_resolved) begin
               fw_q <= 1'b0;
               fr_q <= 1'b1;
            end
         end else if (flt_valid && flt_block)
            fw_q <= 1'b1;
         else if (flt_valid) begin
            cv_q <= 1'b1;
            fh_q <= flt_handle;
            cm_q <= f_ofs;
            fa_q <= f_ofs ? 64'h0 : flt_addr;
            fo_q <= flt_operand;
            fb_q <= flt_bytes;
         end
      end
   end

   assign flt_wait        = fw_q;
   assign flt_resume      = fr_q;
   assign cmp_valid       = cv_q;
   assign cmp_handle      = fh_q;
   assign cmp_fault_addr  = fa_q;
   assign cmp_addr_masked = cm_q;
   assign cmp_operand     = fo_q;
   assign cmp_bytes       = fb_q;

   // ------------------------------------------------------------
   // interrupt status, write one to clear, set wins
   // ------------------------------------------------------------
   wire [`IDW_IRQ_W-1:0] ev = {cv_q, ud_q, cd_q && (cc_q != `IDW_RC_OK)};
   wire [`IDW_IRQ_W-1:0] clr = (wr_go && awa_q == `IDW_OFS_STAT) ?
                               (wd_q[`IDW_IRQ_W-1:0] & {3{ws_q[0]}}) : 3'h0;

   always @(posedge mclk) begin
      if (!rst_b) begin
         stat_q <= 3'h0;
         mask_q <= 3'h0;
      end else begin
         stat_q <= (stat_q & ~clr) | ev;
         if (wr_go && awa_q == `IDW_OFS_MASK)
            mask_q <= wr_val[`IDW_IRQ_W-1:0];
      end
   end

   assign irq = |(stat_q & mask_q);

endmodule // idw_check

`default_nettype wire

// ===== verification/idw_check_assertions.sv
// checker for the window check top: check answer, fault record, update timing
// assumes one clock domain and a synchronous active-low reset
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module idw_check_sva #(
   parameter HW = 2
) (
   // clock, reset, check
   input wire logic          mclk,
   input wire logic          rst_b,
   input wire logic          chk_valid,
   input wire logic [HW-1:0] chk_handle,
   input wire logic          chk_done,
   input wire logic [HW-1:0] chk_res_handle,
   // fault path
   input wire logic          flt_valid,
   input wire logic [HW-1:0] flt_handle,
   input wire logic          flt_block,
   input wire logic          flt_wait,
   input wire logic          flt_resolved,
   input wire logic          flt_resume,
   input wire logic          cmp_valid,
   input wire logic [HW-1:0] cmp_handle,
   input wire logic [63:0]   cmp_fault_addr,
   input wire logic          cmp_addr_masked,
   // update window
   input wire logic          upd_valid,
   input wire logic          upd_ready,
   input wire logic          upd_no_drain,
   input wire logic          upd_done
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   a_chk_answer: assert property (chk_valid |=> chk_done)
      else $error("check not answered");
   a_chk_cause: assert property (chk_done |-> $past(chk_valid))
      else $error("check answer without request");
   a_chk_handle: assert property (
      chk_valid |=> chk_res_handle == $past(chk_handle))
      else $error("check handle differs");
   a_cmp_handle: assert property (
      flt_valid && !flt_block && !flt_wait |=> cmp_valid && cmp_handle == $past(flt_handle))
      else $error("fault record handle wrong");
   a_mask_hides: assert property (cmp_valid && cmp_addr_masked |-> cmp_fault_addr == 64'h0)
      else $error("masked fault shows address");
   a_block_wait: assert property (
      flt_valid && flt_block && !flt_wait |=> flt_wait && !cmp_valid)
      else $error("blocked fault not waiting");
   a_resume_next: assert property (flt_wait && flt_resolved |=> flt_resume)
      else $error("no resume after resolution");
   a_no_drain: assert property (upd_valid && upd_ready && upd_no_drain |=> upd_done)
      else $error("update without drain is late");
endmodule // idw_check_sva

bind idw_check idw_check_sva #(.HW(HW)) i_sva (.*);
`default_nettype wire

// ===== verification/idw_mem_model.sv
// memory path model: submitter bitmap, descriptor retirement, fault resolution
// assumes the check port of idw_check; retires each granted check after DLY cycles
`default_nettype none
module idw_mem_model #(
   parameter             HW   = 2,
   parameter             DLY  = 6,
   parameter logic [15:0] BMAP = 16'h0008
) (
   // clock and reset
   input  wire logic          mclk,
   input  wire logic          rst_b,
   // check side
   input  wire logic          chk_done,
   input  wire logic [2:0]    chk_code,
   input  wire logic [HW-1:0] chk_res_handle,
   input  wire logic [19:0]   chk_pasid,
   output logic              chk_bm_ok,
   output logic              desc_done,
   output logic [HW-1:0]     desc_done_handle,
   // fault side
   input  wire logic          flt_wait,
   output logic              flt_resolved
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DLY-1:0] ok_q;
   logic [HW-1:0]  h_q [DLY];
   logic [2:0]     wt_q;

   assign chk_bm_ok = BMAP[chk_pasid[3:0]];
   assign desc_done = ok_q[DLY-1];
   assign desc_done_handle = h_q[DLY-1];
   // slow resolution keeps the blocked fault visible for a few cycles
   assign flt_resolved = (wt_q == 3'h4);

   always @(posedge mclk) begin
      if (!rst_b) begin
         ok_q <= '0;
         wt_q <= 3'h0;
      end else begin
         ok_q <= {ok_q[DLY-2:0], chk_done && chk_code == 3'h0};
         wt_q <= (flt_wait && !flt_resolved) ? wt_q + 3'h1 : 3'h0;
      end
      h_q[0] <= chk_res_handle;
      for (int i = 1; i < DLY; i++) begin
         h_q[i] <= h_q[i-1];
      end
   end
endmodule // idw_mem_model
`default_nettype wire

// ===== verification/test_inter_domain_window_check.sv
// bench for the window check: register bus, checks, updates, faults, interrupt
// assumes idw_check with default parameters and the memory-path model
`default_nettype none
module test_inter_domain_window_check;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'h0;
   logic        rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, chk_valid, chk_bm_ok, chk_rd, chk_wr, chk_done, desc_done;
   logic        upd_valid, upd_ready, upd_no_drain, upd_mode, upd_rd, upd_wr, upd_wen;
   logic        upd_done, upd_err, irq, flt_valid, flt_block, flt_resolved, flt_wait;
   logic        flt_resume, cmp_valid, cmp_addr_masked, e, ue;
   logic [1:0]  chk_handle, chk_res_handle, desc_done_handle, upd_handle, flt_handle;
   logic [1:0]  cmp_handle, s_axi_bresp, s_axi_rresp, flt_operand, cmp_operand, rr;
   logic [2:0]  chk_code;
   logic [3:0]  s_axi_wstrb;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [19:0] chk_pasid, chk_acc_pasid, upd_pasid;
   logic [31:0] s_axi_wdata, s_axi_rdata, flt_bytes, cmp_bytes, rv;
   logic [63:0] chk_addr, chk_size, chk_eff_addr, upd_base, upd_size, flt_addr, cmp_fault_addr;
   int          n_fail = 0, cmp_count = 0, cyc;

   idw_check i_dut (.*);
   idw_mem_model i_mem (.*);
   always #2 mclk = ~mclk;

   task chk(input logic [127:0] s, x, input string nm);
      cmp_count++;
      if (s !== x) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, x, s);
      end
   endtask

   task conclude;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      logic ta, tw, tr, td;
      if (w) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do begin
         @(negedge mclk);
         {ta, tw} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready};
         {tr, td} = {s_axi_arvalid & s_axi_arready, s_axi_bvalid | s_axi_rvalid};
         {rv, rr} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
         @(posedge mclk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
         if (tr) s_axi_arvalid <= 1'h0;
      end while (!td);
      {s_axi_bready, s_axi_rready} <= 2'h0;
      @(posedge mclk);
   endtask

   task rdc(input logic [11:0] a, input logic [31:0] x, input string nm);
      acc(1'h0, a, 32'h0);
      chk(rv, x, nm);
   endtask

   // usable bit goes last so the entry is never live half written
   task cfg(input logic [11:0] a, input logic [31:0] c, s, p, b, z);
      acc(1'h1, a, c);
      acc(1'h1, a + 12'h4, s);
      acc(1'h1, a + 12'h8, p);
      acc(1'h1, a + 12'hC, b);
      acc(1'h1, a + 12'h14, z);
      acc(1'h1, a, c | 32'h1);
   endtask

   task dchk(input logic [1:0] h, input logic [19:0] p, input logic [1:0] rw,
             input logic [63:0] a, s, input logic [2:0] c);
      {chk_handle, chk_pasid, chk_rd, chk_wr, chk_addr, chk_size} <= {h, p, rw, a, s};
      chk_valid <= 1'h1;
      @(posedge mclk);
      chk_valid <= 1'h0;
      @(negedge mclk);
      chk(chk_done, 1'h1, "chk_done");
      chk(chk_code, c, "chk_code");
      @(posedge mclk);
   endtask

   task upd(input logic [1:0] h, input logic [19:0] p, input logic nd, wn, wr,
            input logic [63:0] b);
      {upd_handle, upd_pasid, upd_no_drain, upd_wen, upd_wr, upd_base} <= {h, p, nd, wn, wr, b};
      {upd_size, upd_mode, upd_rd, upd_valid} <= {64'h1000, 3'h3};
      do begin
         @(negedge mclk);
         e = upd_ready;
         @(posedge mclk);
      end while (!e);
      upd_valid <= 1'h0;
      cyc = 0;
      do begin
         @(negedge mclk);
         cyc++;
         {e, ue} = {upd_done, upd_err};
         @(posedge mclk);
      end while (!e);
   endtask

   task flt(input logic [1:0] h, input logic b);
      {flt_handle, flt_block, flt_operand, flt_bytes, flt_addr} <= {h, b, 2'h1, 32'h40, 64'h5000};
      flt_valid <= 1'h1;
      @(posedge mclk);
      flt_valid <= 1'h0;
      @(negedge mclk);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
      {chk_valid, upd_valid, flt_valid, s_axi_wstrb, rst_b} <= 8'h1E;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, chk_handle, chk_pasid, chk_rd, chk_wr} <= '0;
      {chk_addr, chk_size, upd_handle, upd_pasid, upd_no_drain, upd_base, upd_size} <= '0;
      {upd_mode, upd_rd, upd_wr, upd_wen, flt_handle, flt_block, flt_operand} <= '0;
      {flt_bytes, flt_addr} <= '0;
      repeat (12) @(posedge mclk);
      rst_b <= 1'h1;
      @(posedge mclk);
      rdc(12'h000, 32'h0, "stat reset");
      rdc(12'h100, 32'h0, "ctrl reset");
      rdc(12'hFFC, 32'h0, "unmapped");
      chk(rr, 2'h2, "unmapped resp");
      cfg(12'h100, 32'h52, 32'h5, 32'h7, 32'h1000, 32'h1000);
      cfg(12'h120, 32'hF4, 32'h0, 32'h9, 32'h4000, 32'h100);
      rdc(12'h100, 32'h53, "ctrl0");
      $display("test registers done");
      dchk(2'h0, 20'h5, 2'h2, 64'h1000, 64'h100, 3'h0);
      dchk(2'h0, 20'h5, 2'h2, 64'h1F00, 64'h100, 3'h0);
      dchk(2'h0, 20'h5, 2'h2, 64'h1F00, 64'h101, 3'h5);
      dchk(2'h0, 20'h5, 2'h2, 64'hFFF, 64'h1, 3'h5);
      dchk(2'h0, 20'h5, 2'h1, 64'h1000, 64'h10, 3'h4);
      dchk(2'h0, 20'h6, 2'h2, 64'h1000, 64'h10, 3'h2);
      dchk(2'h2, 20'h5, 2'h2, 64'h1000, 64'h10, 3'h1);
      dchk(2'h1, 20'h4, 2'h2, 64'h10, 64'h10, 3'h2);
      dchk(2'h1, 20'h3, 2'h2, 64'hF8, 64'h10, 3'h5);
      dchk(2'h1, 20'h3, 2'h2, 64'hFFFF_FFFF_FFFF_FFF0, 64'h20, 3'h5);
      dchk(2'h1, 20'h3, 2'h3, 64'h10, 64'h10, 3'h0);
      chk({chk_acc_pasid, chk_eff_addr}, {20'h9, 64'h4010}, "eff addr");
      $display("test checks done");
      upd(2'h1, 20'h9, 1'h1, 1'h1, 1'h0, 64'h4000);
      chk(ue, 1'h1, "upd no allow");
      upd(2'h0, 20'h5, 1'h1, 1'h1, 1'h0, 64'h1000);
      chk(ue, 1'h1, "upd pasid");
      dchk(2'h0, 20'h5, 2'h2, 64'h1000, 64'h100, 3'h0);
      upd(2'h0, 20'h7, 1'h0, 1'h1, 1'h0, 64'h1000);
      chk({cyc > 2, ue}, 2'h2, "drain wait");
      upd(2'h0, 20'h7, 1'h1, 1'h0, 1'h1, 64'h0);
      chk(cyc, 1'h1, "no drain");
      rdc(12'h100, 32'hC3, "ctrl0 upd");
      rdc(12'h104, 32'h5, "subm kept");
      dchk(2'h0, 20'h5, 2'h1, 64'h9000_0000_0000, 64'h10, 3'h0);
      $display("test updates done");
      flt(2'h1, 1'h0);
      chk({cmp_valid, cmp_addr_masked, cmp_handle}, 4'hD, "cmp flags");
      chk({cmp_fault_addr, cmp_operand, cmp_bytes}, 98'h1_0000_0040, "cmp data");
      @(posedge mclk);
      flt(2'h0, 1'h0);
      chk({cmp_addr_masked, cmp_fault_addr}, 65'h5000, "cmp addr");
      @(posedge mclk);
      flt(2'h0, 1'h1);
      chk({flt_wait, cmp_valid}, 2'h2, "blocked");
      for (cyc = 0; cyc < 20 && flt_resume !== 1'h1; cyc++) @(negedge mclk);
      chk(flt_resume, 1'h1, "resume");
      @(posedge mclk);
      $display("test faults done");
      rdc(12'h000, 32'h7, "stat");
      chk(irq, 1'h0, "irq masked");
      acc(1'h1, 12'h004, 32'h4);
      chk({irq, rr}, 3'h4, "irq on");
      acc(1'h1, 12'h000, 32'h4);
      chk(irq, 1'h0, "irq cleared");
      rdc(12'h000, 32'h3, "stat cleared");
      $display("test interrupt done");
      conclude;
   end

   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      conclude;
   end
endmodule // test_inter_domain_window_check
`default_nettype wire
